// File: core/asp_serial_port.sv
// control and serial readout of a delta-sigma converter
// assumes pins are asynchronous to clock and sampled here;
// the filter result comes from logic on the same clock
//
// Operation
// - word ready 1624 master cycles after start
// - flag high two master cycles before update
// - load only if port empty or unselected
// - flag low whenever a word is loaded
// - select low drives out msb at once
// - first rise arms, falls shift msb first
// - falling edge before arming is ignored
// - fall on lsb: tristate, flag high, empty
// - output tristate whenever not transmitting
// - unselected flag rises before next word
// - convert rise with calibrate high calibrates
// - convert rise with calibrate low converts once
// - convert held high converts back to back
// - polarity high bipolar, low unipolar
// - stopped master clock enters reduced power
// - straight binary unipolar, offset binary bipolar
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/10ps

module asp_serial_port (
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // device pins
  input wire logic master_clock_in,
  input wire logic begin_sampling,
  input wire logic cal_select,
  input wire logic polarity_select,
  input wire logic port_select_n,
  input wire logic shift_clock,
  output logic word_ready_flag_n,
  output logic serial_out,
  output logic serial_out_en_n,
  // filter and modulator side
  input wire logic [15:0] filter_result,
  output logic modulator_run,
  output logic cal_active,
  output logic bipolar_mode,
  output logic low_power
);

  // ==========================================================
  // state
  asp_pkg::asp_state_t st_reg;
  asp_pkg::asp_state_t st_next;
  logic mclk_tick;
  logic begin_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_active;
  logic apb_access;
  logic addr_hit;
  logic [15:0] coded_word;
  logic [31:0] read_value;

  // ==========================================================
  // output coding
  // output coding
  // the filter hands over two's complement; unipolar results
  // below zero clip to code zero, so negative overrange is lost
  function automatic logic [15:0] code_word(
    input logic [15:0] raw,
    input logic bip
  );
    logic [15:0] w;
    w = 16'h0000;
    if (bip) begin
      w = {~raw[15], raw[14:0]};
    end else if (raw[15]) begin
      w = 16'h0000;
    end else begin
      w = {raw[14:0], 1'b0};
    end
    return w;
  endfunction : code_word

  // ==========================================================
  // edges of synchronised pins
  // only the second and third stages are looked at here
  assign mclk_tick = st_reg.s2[asp_pkg::SY_MCLK] &
    ~st_reg.s3[asp_pkg::SY_MCLK];
  assign begin_rise = st_reg.s2[asp_pkg::SY_BEGIN] &
    ~st_reg.s3[asp_pkg::SY_BEGIN];
  assign sclk_rise = st_reg.s2[asp_pkg::SY_SCLK] &
    ~st_reg.s3[asp_pkg::SY_SCLK];
  assign sclk_fall = ~st_reg.s2[asp_pkg::SY_SCLK] &
    st_reg.s3[asp_pkg::SY_SCLK];
  assign sel_active = ~st_reg.s2[asp_pkg::SY_SEL];
  assign coded_word = code_word(filter_result, st_reg.bipolar);

  // ==========================================================
  // register decode
  assign apb_access = psel & penable;
  assign addr_hit = (paddr == asp_pkg::ADDR_CONTROL) |
    (paddr == asp_pkg::ADDR_STATUS) |
    (paddr == asp_pkg::ADDR_MASK) |
    (paddr == asp_pkg::ADDR_STATE) |
    (paddr == asp_pkg::ADDR_WORD);

  // read mux; unmapped offsets read as zero
  always_comb begin
    read_value = 32'h0000_0000;
    case (paddr)
      asp_pkg::ADDR_CONTROL: begin
        read_value = {31'h0000_0000, st_reg.enable};
      end
      asp_pkg::ADDR_STATUS: begin
        read_value = {27'h000_0000, st_reg.status};
      end
      asp_pkg::ADDR_MASK: begin
        read_value = {27'h000_0000, st_reg.mask};
      end
      asp_pkg::ADDR_STATE: begin
        read_value = {24'h00_0000, st_reg.low_power,
          st_reg.calibrated, st_reg.bipolar, st_reg.port_full,
          st_reg.sending, st_reg.ready_n, st_reg.phase};
      end
      asp_pkg::ADDR_WORD: begin
        read_value = {16'h0000, st_reg.last_word};
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    logic [asp_pkg::EV_W-1:0] ev;
    logic [11:0] cnt_inc;
    ev = '0;
    st_next = st_reg;
    cnt_inc = 12'(st_reg.mcount + 12'h001);

    // two-stage synchronisers plus an edge history stage
    st_next.s1 = {shift_clock, port_select_n, polarity_select,
      cal_select, begin_sampling, master_clock_in};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;

    // clock loss watchdog
    // the counter only restarts on a master edge, so a stalled
    // crystal freezes the conversion where it stood
    if (mclk_tick) begin
      st_next.idle_cnt = 12'h000;
      st_next.low_power = 1'b0;
    end else if (st_reg.idle_cnt != asp_pkg::LOSS_CYCLES) begin
      st_next.idle_cnt = 12'(st_reg.idle_cnt + 12'h001);
    end else if (!st_reg.low_power) begin
      st_next.low_power = 1'b1;
      ev[asp_pkg::EV_CLK_LOST] = 1'b1;
    end

    // ------------------------------------------------------
    // serial port
    if (!sel_active) begin
      // idle tristate
      // deselect mid-word keeps the word; the next select
      // restarts it from the top bit
      st_next.sending = 1'b0;
      st_next.armed = 1'b0;
      st_next.bit_idx = asp_pkg::MSB_IDX;
      st_next.sdo_en_n = 1'b1;
    end else if (st_reg.port_full && !st_reg.sending) begin
      st_next.sending = 1'b1;
      st_next.armed = 1'b0;
      st_next.bit_idx = asp_pkg::MSB_IDX;
      st_next.sdo = st_reg.port_word[asp_pkg::MSB_IDX];
      st_next.sdo_en_n = 1'b0;
    end else if (st_reg.sending) begin
      if (sclk_rise) begin
        st_next.armed = 1'b1;
      end
      if (sclk_fall && st_reg.armed) begin
        if (st_reg.bit_idx == 4'h0) begin
          st_next.sending = 1'b0;
          st_next.armed = 1'b0;
          st_next.sdo_en_n = 1'b1;
          st_next.ready_n = 1'b1;
          st_next.port_full = 1'b0;
          ev[asp_pkg::EV_READOUT] = 1'b1;
        end else begin
          st_next.bit_idx = 4'(st_reg.bit_idx - 4'h1);
          st_next.sdo = st_reg.port_word[
            4'(st_reg.bit_idx - 4'h1)];
        end
      end
    end

    // ------------------------------------------------------
    // conversion sequencer, stepped by master clock edges
    case (st_reg.phase)
      asp_pkg::ASP_IDLE: begin
        if (begin_rise && st_reg.enable) begin
          st_next.mcount = 12'h000;
          st_next.bipolar = st_reg.s2[asp_pkg::SY_POL];
          if (st_reg.s2[asp_pkg::SY_CAL]) begin
            st_next.phase = asp_pkg::ASP_CALIBRATE;
          end else begin
            st_next.phase = asp_pkg::ASP_CONVERT;
          end
        end
      end
      asp_pkg::ASP_CONVERT: begin
        if (mclk_tick) begin
          st_next.mcount = cnt_inc;
          if (cnt_inc == asp_pkg::FLAG_AT) begin
            st_next.ready_n = 1'b1;
          end
          if (cnt_inc == asp_pkg::BEGIN_SAMPLING_MCLKS) begin
            if (!st_next.port_full || !sel_active) begin
              st_next.port_word = coded_word;
              st_next.last_word = coded_word;
              st_next.port_full = 1'b1;
              st_next.sending = 1'b0;
              st_next.armed = 1'b0;
              st_next.bit_idx = asp_pkg::MSB_IDX;
              st_next.ready_n = 1'b0;
              ev[asp_pkg::EV_LOADED] = 1'b1;
            end else begin
              ev[asp_pkg::EV_DROPPED] = 1'b1;
            end
            st_next.mcount = 12'h000;
            if (st_reg.s2[asp_pkg::SY_BEGIN] &&
                !st_reg.s2[asp_pkg::SY_CAL] && st_reg.enable) begin
              st_next.phase = asp_pkg::ASP_CONVERT;
              st_next.bipolar = st_reg.s2[asp_pkg::SY_POL];
            end else begin
              st_next.phase = asp_pkg::ASP_IDLE;
            end
          end
        end
      end
      asp_pkg::ASP_CALIBRATE: begin
        if (mclk_tick) begin
          st_next.mcount = cnt_inc;
          if (cnt_inc == asp_pkg::CAL_MCLKS) begin
            st_next.mcount = 12'h000;
            st_next.calibrated = 1'b1;
            st_next.phase = asp_pkg::ASP_IDLE;
            ev[asp_pkg::EV_CAL_DONE] = 1'b1;
          end
        end
      end
      default: begin
        st_next.phase = asp_pkg::ASP_IDLE;
      end
    endcase

    // ------------------------------------------------------
    // apb slave: one wait state, then pready for one cycle
    if (apb_access && !st_reg.pready) begin
      st_next.pready = 1'b1;
      st_next.pslverr = ~addr_hit;
      st_next.prdata = read_value;
      // remember exactly what software is about to see
      st_next.snap = (paddr == asp_pkg::ADDR_STATUS && !pwrite) ?
        st_reg.status : '0;
    end else if (apb_access && st_reg.pready) begin
      // transfer completes at this edge
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      if (pwrite && paddr == asp_pkg::ADDR_CONTROL) begin
        st_next.enable = pwdata[asp_pkg::CTRL_EN_BIT];
      end
      if (pwrite && paddr == asp_pkg::ADDR_MASK) begin
        st_next.mask = pwdata[asp_pkg::EV_W-1:0];
      end
      // read clears only the bits that were reported
      st_next.status = st_reg.status & ~st_reg.snap;
      st_next.snap = '0;
    end else begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
    end

    // new events win over a clear in the same cycle
    st_next.status = st_next.status | ev;
    st_next.irq = |(st_next.status & st_next.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.s1 <= asp_pkg::SYNC_RESET;
      st_reg.s2 <= asp_pkg::SYNC_RESET;
      st_reg.s3 <= asp_pkg::SYNC_RESET;
      st_reg.phase <= asp_pkg::ASP_IDLE;
      st_reg.enable <= asp_pkg::CTRL_EN_RESET;
      st_reg.bit_idx <= asp_pkg::MSB_IDX;
      st_reg.ready_n <= 1'b1;
      st_reg.sdo_en_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs, all taken from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;
  assign word_ready_flag_n = st_reg.ready_n;
  assign serial_out = st_reg.sdo;
  assign serial_out_en_n = st_reg.sdo_en_n;
  assign modulator_run = (st_reg.phase != asp_pkg::ASP_IDLE);
  assign cal_active = (st_reg.phase == asp_pkg::ASP_CALIBRATE);
  assign bipolar_mode = st_reg.bipolar;
  assign low_power = st_reg.low_power;

endmodule : asp_serial_port

// File: shared/asp_pkg.sv
// constants, field layouts and state types of the converter serial port
// assumes one 20 MHz system clock; all pins arrive asynchronously
package asp_pkg;

  // ==========================================================
  // word and timing
  localparam int WORD_BITS = 16;
  localparam logic [3:0] MSB_IDX = 4'hf;
  localparam int CLK_PERIOD_NS = 50;
  // master clock cycles from start to finished word
  localparam logic [11:0] BEGIN_SAMPLING_MCLKS = 12'h658;
  // flag goes high this many master cycles before the update
  localparam logic [11:0] READY_LEAD = 12'h002;
  localparam logic [11:0] FLAG_AT = BEGIN_SAMPLING_MCLKS - READY_LEAD;
  // self-calibration length in master cycles
  localparam logic [11:0] CAL_MCLKS = 12'hcb0;
  // no master edge for this long means the clock has stopped
  localparam int LOSS_TIME_NS = 100000;
  localparam logic [11:0] LOSS_CYCLES =
    12'(LOSS_TIME_NS / CLK_PERIOD_NS);

  // ==========================================================
  // synchroniser lanes
  localparam int SY_W = 6;
  localparam int SY_MCLK = 0;
  localparam int SY_BEGIN = 1;
  localparam int SY_CAL = 2;
  localparam int SY_POL = 3;
  localparam int SY_SEL = 4;
  localparam int SY_SCLK = 5;
  // select idles inactive high out of reset
  localparam logic [SY_W-1:0] SYNC_RESET = 6'h10;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0c;
  localparam logic [7:0] ADDR_WORD = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;

  // event bits, shared by status and mask
  localparam int EV_W = 5;
  localparam int EV_LOADED = 0;
  localparam int EV_DROPPED = 1;
  localparam int EV_CAL_DONE = 2;
  localparam int EV_CLK_LOST = 3;
  localparam int EV_READOUT = 4;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ASP_IDLE,
    ASP_CONVERT,
    ASP_CALIBRATE
  } asp_phase_t;

  typedef struct packed {
    logic [SY_W-1:0] s1;
    logic [SY_W-1:0] s2;
    logic [SY_W-1:0] s3;
    asp_phase_t phase;
    logic [11:0] mcount;
    logic [11:0] idle_cnt;
    logic low_power;
    logic calibrated;
    logic bipolar;
    logic enable;
    logic [WORD_BITS-1:0] port_word;
    logic [WORD_BITS-1:0] last_word;
    logic port_full;
    logic sending;
    logic armed;
    logic [3:0] bit_idx;
    logic ready_n;
    logic sdo;
    logic sdo_en_n;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] snap;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } asp_state_t;

endpackage : asp_pkg

// File: sim/asp_monitor.sv
// checker on the serial port pins and the bus handshake
// assumes the host holds select steady for many cycles around a frame
`timescale 1ns/10ps
module asp_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic polarity_select,
  input wire logic port_select_n,
  input wire logic shift_clock,
  input wire logic word_ready_flag_n,
  input wire logic serial_out,
  input wire logic serial_out_en_n,
  input wire logic modulator_run,
  input wire logic cal_active,
  input wire logic bipolar_mode
);
  // ==========
  // properties
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_LOAD_EMPTY: assert property (
    $fell(word_ready_flag_n) |-> $past(serial_out_en_n))
    else $error("word loaded while sending");
  AST_LEAD: assert property (
    $fell(word_ready_flag_n) |-> $past(word_ready_flag_n, 8))
    else $error("flag not high before update");
  AST_MSB_SEL: assert property (
    $fell(serial_out_en_n) |->
      !$past(port_select_n, 2) && !word_ready_flag_n)
    else $error("data driven without select or word");
  AST_SHIFT_FALL: assert property (
    $changed(serial_out) && !serial_out_en_n && !$past(serial_out_en_n)
      |-> !$past(shift_clock, 2))
    else $error("data moved off a falling edge");
  AST_LAST_BIT: assert property (
    $rose(serial_out_en_n) && !port_select_n && !$past(port_select_n, 4)
      |-> word_ready_flag_n)
    else $error("flag low after full readout");
  AST_IDLE_HIZ: assert property (
    port_select_n [*5] |-> serial_out_en_n)
    else $error("data driven while unselected");
  AST_CAL_RUN: assert property (
    cal_active |-> modulator_run)
    else $error("calibration without modulator");
  AST_MODE: assert property (
    $rose(modulator_run) |-> ##[0:2] bipolar_mode == polarity_select)
    else $error("mode not taken from pin");
  AST_APB_ONE: assert property (
    pready |-> $past(psel && penable) ##1 !pready)
    else $error("bus answer wrong");
endmodule : asp_monitor

bind asp_serial_port asp_monitor asp_monitor_inst (
  .clock, .rst_n, .psel, .penable, .pready, .polarity_select,
  .port_select_n, .shift_clock, .word_ready_flag_n, .serial_out,
  .serial_out_en_n, .modulator_run, .cal_active, .bipolar_mode
);

// File: sim/asp_host_model.sv
// host model: reads words over select, shift clock and data line
// assumes the bench clock paces it; the line floats when released
`timescale 1ns/10ps
module asp_host_model (
  input wire logic clock,
  input wire logic serial_out,
  input wire logic serial_out_en_n,
  output logic port_select_n,
  output logic shift_clock
);
  logic last_level;
  wire logic line_level;
  // ==========
  // data line
  // a released line flips each cycle so a stale bit cannot pass
  assign line_level = serial_out_en_n ? ~last_level : serial_out;
  always @(posedge clock) begin
    last_level <= line_level;
  end
  initial begin
    port_select_n = 1'b1;
    shift_clock = 1'b0;
    last_level = 1'b0;
  end
  // ==========
  // frame tasks
  task automatic select(input logic v);
    @(posedge clock);
    port_select_n <= v;
  endtask : select
  // shift clock stands still outside a frame
  task automatic read_word(input logic hi, input int half,
    output logic [15:0] w);
    @(posedge clock);
    shift_clock <= hi;
    port_select_n <= 1'b0;
    repeat (20) @(posedge clock);
    if (hi) begin
      shift_clock <= 1'b0;
      repeat (half) @(posedge clock);
    end
    for (int i = 15; i >= 0; i--) begin
      shift_clock <= 1'b1;
      repeat (half) @(posedge clock);
      w[i] = line_level;
      shift_clock <= 1'b0;
      repeat (half) @(posedge clock);
    end
    repeat (half) @(posedge clock);
    port_select_n <= 1'b1;
  endtask : read_word
endmodule : asp_host_model

// File: sim/asp_serial_port_tb.sv
// bench: drives the serial port block and checks it against a model
// assumes the package, host model and bound checker are compiled first
`timescale 1ns/10ps
module asp_serial_port_tb;
  localparam int MP = 6;  // master period in clock cycles
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, master_clock_in = 1'b0, mclk_run = 1'b1;
  logic begin_sampling = 1'b0, cal_select = 1'b0, polarity_select = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] filter_result = 16'h0000, lfsr = 16'h005b, port_exp, got;
  logic pready, pslverr, irq, port_select_n, shift_clock, er;
  logic word_ready_flag_n, serial_out, serial_out_en_n;
  logic modulator_run, cal_active, bipolar_mode, low_power;
  logic [15:0] raw_q[$];
  int err_total = 0, samples_checked = 0, cyc = 0, n;

  asp_serial_port asp_serial_port_inst (
    .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .master_clock_in, .begin_sampling,
    .cal_select, .polarity_select, .port_select_n, .shift_clock,
    .word_ready_flag_n, .serial_out, .serial_out_en_n, .filter_result,
    .modulator_run, .cal_active, .bipolar_mode, .low_power
  );
  asp_host_model asp_host_model_inst (
    .clock, .serial_out, .serial_out_en_n, .port_select_n, .shift_clock
  );

  // ==========
  // clocks and hang guard
  always #25 clock = ~clock;
  // stopping the master clock exercises the loss detector
  always #150 if (mclk_run) master_clock_in = ~master_clock_in;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      wrap_up();
    end
  end

  // ==========
  // model and helpers
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // unipolar clips negatives, bipolar is offset binary
  function automatic logic [15:0] exp_code(logic [15:0] r, logic b);
    if (b) return {~r[15], r[14:0]};
    if (r[15]) return 16'h0000;
    return {r[14:0], 1'b0};
  endfunction : exp_code
  function automatic logic pick(int k);
    if (k == 0) return word_ready_flag_n;
    if (k == 1) return cal_active;
    return modulator_run;
  endfunction : pick
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string m);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %h", $time, m, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(k < 20, 1, "bus");
  endtask : apb
  task automatic wait_sig(input int k, input logic v, input int lim);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk(n < lim, 1, "wait");
  endtask : wait_sig
  task automatic new_raw();
    lfsr = lfsr_next(lfsr);
    raw_q.push_back(lfsr);
    @(posedge clock);
    filter_result <= lfsr;
  endtask : new_raw
  task automatic start(input logic cal, input logic pol);
    new_raw();
    cal_select <= cal;
    polarity_select <= pol;
    repeat (4) @(posedge clock);
    begin_sampling <= 1'b1;
  endtask : start
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // ==========
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk(serial_out_en_n, 1, "oe");
    apb(0, asp_pkg::ADDR_CONTROL, 0);
    chk(rd, 32'h0000_0001, "ctrl");
    apb(0, asp_pkg::ADDR_MASK, 0);
    chk(rd, 32'h0000_0000, "mask");
    apb(0, 8'h20, 0);
    chk(er, 1, "unmapped");
    $display("reset test done");
    start(1, 0);
    wait_sig(1, 1, 20);
    begin_sampling <= 1'b0;
    wait_sig(1, 0, 20000);
    apb(0, asp_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h0000_0004, "cal");
    $display("calibration test done");
    apb(1, asp_pkg::ADDR_MASK, 32'h0000_0001);
    start(0, 0);
    port_exp = exp_code(raw_q[$], 1'b0);
    repeat (8) @(posedge clock);
    begin_sampling <= 1'b0;
    wait_sig(0, 0, 12000);
    chk(n + 8 >= 1623 * MP + 5 && n + 8 <= 1624 * MP + 10, 1, "lat");
    wait_sig(2, 0, 50);
    chk(irq, 1, "irq");
    apb(0, asp_pkg::ADDR_WORD, 0);
    chk(rd, {16'h0000, port_exp}, "wreg");
    asp_host_model_inst.read_word(0, 4, got);
    chk(got, port_exp, "uni");
    repeat (4) @(posedge clock);
    chk({word_ready_flag_n, serial_out_en_n}, 2'b11, "empty");
    apb(0, asp_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h0000_0011, "st1");
    // irq drops with the read-clear at the completing edge; one more edge lets the bench see it
    @(posedge clock);
    chk(irq, 0, "clr");
    $display("single conversion test done");
    start(0, 1);
    port_exp = exp_code(raw_q[$], 1'b1);
    wait_sig(0, 0, 12000);
    new_raw();
    asp_host_model_inst.read_word(1, 4, got);
    chk(got, port_exp, "bip");
    wait_sig(0, 0, 12000);
    new_raw();
    port_exp = exp_code(raw_q[$], 1'b1);
    wait_sig(0, 1, 12000);
    wait_sig(0, 0, 40);
    chk(n >= 2 * MP - 1 && n <= 2 * MP + 2, 1, "lead");
    new_raw();
    asp_host_model_inst.select(0);
    begin_sampling <= 1'b0;
    wait_sig(0, 1, 12000);
    repeat (40) @(posedge clock);
    chk(word_ready_flag_n, 1, "drop");
    asp_host_model_inst.read_word(0, 4, got);
    chk(got, port_exp, "kept");
    chk(irq, 1, "irq2");
    apb(0, asp_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h0000_0013, "st2");
    chk(modulator_run, 0, "stop");
    $display("continuous test done");
    mclk_run <= 1'b0;
    repeat (2100) @(posedge clock);
    chk(low_power, 1, "lp");
    apb(0, asp_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h0000_0008, "lost");
    chk(irq, 0, "masked");
    $display("clock loss test done");
    wrap_up();
  end
endmodule : asp_serial_port_tb
